// ==== logic/host_port.sv ====
// Purpose: host parallel port reaching on-chip memory over an internal dma path
// Assumes: memory answers a granted read on the next clock
// Notes: strobes and select pass a three-stage synchroniser
// Functional notes
// - separate read and write address registers
// - dual bit: shared or independent address registers
// - single mode address write loads both
// - single mode auto-increment bumps both registers
// - single mode address read returns read register
// - dual mode select bit picks one register
// - select bit never steers memory addressing
// - dual mode increments only the used register
// - strap sampled at reset selects interface mode
// - narrow variant with strap low disables port
// - address strobe optional, byte line muxed only
// - wide mode uses 15-bit address bus
// - ready low while resources busy
// - control inputs captured first, then access starts
// - read fetches memory, ready high when valid
// - write latched at strobe rise, then stored
// - cpu wins shared block contention
// - host and dma controller round-robin per half
// - access codes: control, data inc, address, data
// - direction high reads, low writes
// - ready forced high while not selected
module host_port
   import host_port_pkg::*;
   #(
      parameter bit WIDE_PRESENT = 1'b1
   )
   (
      // clock and reset
      input wire logic clk_sys,
      input wire logic resetn,
      // host control pins
      input wire logic portSelectN,
      input wire logic dataStrobeAN,
      input wire logic dataStrobeBN,
      input wire logic addrStrobeN,
      input wire logic [1:0] accessTypeInputs,
      input wire logic directionInput,
      input wire logic byteIdLine,
      input wire logic modeStrapPin,
      // host buses
      input wire logic [ADDR_W-1:0] hostAddrBus,
      input wire logic [DATA_W-1:0] hostDataIn,
      output logic [DATA_W-1:0] hostDataOut,
      output logic hostDataOe,
      output logic portReadyOut,
      // memory port
      output logic memEnable,
      output logic memWrite,
      output logic [MEM_AW-1:0] memAddr,
      output logic [DATA_W-1:0] memWdata,
      input wire logic [DATA_W-1:0] memRdata,
      // other memory masters
      input wire logic cpuReq,
      input wire logic [BLOCK_W-1:0] cpuBlock,
      input wire logic dmacReq,
      input wire logic [BLOCK_W-1:0] dmacBlock,
      output logic dmacGrant,
      // status
      output logic muxModeOut,
      output logic portEnabledOut
   );

   pins_s pinRaw;
   pins_s sync1_q;
   pins_s sync2_q;
   pins_s sync3_q;
   pins_s pin_q;
   pins_s agree;
   logic [2:0] upCnt_q;
   logic modeValid_q;
   logic muxMode_q;
   logic portOn;
   logic csActive;
   logic strobeAct;
   logic captured_q;
   logic capture;
   logic asPrev_q;
   logic asFall;
   logic preValid_q;
   access_e preAcc_q;
   logic preDirRead_q;
   logic preSecond_q;
   access_e curAcc;
   logic curDirRead;
   logic curSecond;
   access_e acc_q;
   logic dirRead_q;
   logic second_q;
   state_e state_q;
   state_e state_d;
   logic [ADDR_W-1:0] readAddrReg_q;
   logic [ADDR_W-1:0] writeAddrReg_q;
   logic [DATA_W-1:0] portControlReg_q;
   logic [DATA_W-1:0] dataWindowReg_q;
   logic [DATA_W-1:0] hostDataOut_q;
   logic [DATA_W-1:0] ctrlView;
   logic [DATA_W-1:0] addrView;
   logic dualAddrBit;
   logic addrRegSelectBit;
   logic byteOrderBit;
   logic curValid;
   logic curFetch;
   logic wrRise;
   logic hostGnt;
   logic incRead;
   logic incWrite;
   logic busy;

   mem_arb_if arbBus();

   // byte lane of a muxed transfer
   function automatic logic laneHigh(input logic second, input logic byte_order_bit);
      laneHigh = ~(second ^ byte_order_bit);
   endfunction

   // value shown on the data bus for one transfer
   function automatic logic [DATA_W-1:0] readSel(input logic [DATA_W-1:0] w,
                                                 input logic mux, input logic high);
      if (!mux)
      begin
         readSel = w;
      end
      else
      begin
         readSel = {8'h00, high ? w[15:8] : w[7:0]};
      end
   endfunction

   // word after one host write, byte-wise in muxed mode
   function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                               input logic [DATA_W-1:0] din,
                                               input logic mux, input logic high);
      if (!mux)
      begin
         merge = din;
      end
      else if (high)
      begin
         merge = {din[7:0], old[7:0]};
      end
      else
      begin
         merge = {old[15:8], din[7:0]};
      end
   endfunction

   assign pinRaw = {portSelectN, dataStrobeAN, dataStrobeBN, addrStrobeN, accessTypeInputs,
                    directionInput, byteIdLine, hostAddrBus, hostDataIn, modeStrapPin};
   assign agree = ~(sync2_q ^ sync3_q);

   // pin synchroniser, a change counts once stages two and three agree
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         sync1_q <= '1;
         sync2_q <= '1;
         sync3_q <= '1;
         pin_q <= '1;
      end
      else
      begin
         sync1_q <= pinRaw;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         pin_q <= (agree & sync2_q) | (~agree & pin_q);
      end
   end

   // strap caught once the synchroniser has settled after release
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         upCnt_q <= 3'h0;
         modeValid_q <= 1'b0;
         muxMode_q <= 1'b0;
      end
      else if (!modeValid_q)
      begin
         upCnt_q <= upCnt_q + 3'h1;
         if (upCnt_q == STRAP_WAIT)
         begin
            modeValid_q <= 1'b1;
            muxMode_q <= pin_q.strap;
         end
      end
   end

   assign portOn = modeValid_q & (muxMode_q | WIDE_PRESENT);
   assign csActive = ~pin_q.selN;
   assign strobeAct = csActive & (pin_q.strobeAN ^ pin_q.strobeBN);
   assign capture = portOn & strobeAct & ~captured_q & (state_q == ST_IDLE);
   // address strobe counts only in muxed mode
   assign asFall = muxMode_q & asPrev_q & ~pin_q.addrStrobeN;

   // control capture on address strobe or internal strobe fall
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         asPrev_q <= 1'b1;
         preValid_q <= 1'b0;
         preAcc_q <= ACC_CTRL;
         preDirRead_q <= 1'b0;
         preSecond_q <= 1'b0;
      end
      else
      begin
         asPrev_q <= pin_q.addrStrobeN;
         // a fall together with the strobe leaves nothing stale behind
         if (asFall && !capture)
         begin
            preValid_q <= 1'b1;
            preAcc_q <= access_e'(pin_q.acc);
            preDirRead_q <= pin_q.dirRead;
            preSecond_q <= pin_q.byteId;
         end
         else if (capture)
         begin
            preValid_q <= 1'b0;
         end
      end
   end

   assign curAcc = preValid_q ? preAcc_q : access_e'(pin_q.acc);
   assign curDirRead = preValid_q ? preDirRead_q : pin_q.dirRead;
   // byte line ignored in wide mode
   assign curSecond = muxMode_q & (preValid_q ? preSecond_q : pin_q.byteId);
   // address and auto-increment codes exist only in muxed mode
   assign curValid = muxMode_q | (curAcc == ACC_CTRL) | (curAcc == ACC_DATA);
   assign curFetch = curAcc[0] & curValid & ~curSecond;

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         captured_q <= 1'b0;
         acc_q <= ACC_CTRL;
         dirRead_q <= 1'b0;
         second_q <= 1'b0;
      end
      else if (capture)
      begin
         captured_q <= 1'b1;
         acc_q <= curValid ? curAcc : ACC_CTRL;
         // refused code marked as a read so no register takes its write
         dirRead_q <= curDirRead | ~curValid;
         second_q <= curSecond;
      end
      else if (!strobeAct)
      begin
         captured_q <= 1'b0;
      end
   end

   assign byteOrderBit = portControlReg_q[CTL_BOB_BIT];
   assign dualAddrBit = portControlReg_q[CTL_DUAL_BIT];
   assign addrRegSelectBit = portControlReg_q[CTL_SEL_BIT];

   always_comb
   begin
      ctrlView = portControlReg_q;
      ctrlView[CTL_BOB_STAT_BIT] = byteOrderBit;
   end

   // host view of the address registers
   assign addrView = (!dualAddrBit || addrRegSelectBit) ? readAddrReg_q : writeAddrReg_q;

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         ST_IDLE:
         begin
            if (capture)
            begin
               if (!curDirRead)
               begin
                  state_d = ST_WR_LATCH;
               end
               else if (curFetch)
               begin
                  state_d = ST_RD_MEM;
               end
               else
               begin
                  state_d = ST_RD_HOLD;
               end
            end
         end
         ST_RD_MEM:
         begin
            if (hostGnt)
            begin
               state_d = ST_RD_DATA;
            end
         end
         ST_RD_DATA:
         begin
            state_d = ST_RD_HOLD;
         end
         ST_RD_HOLD:
         begin
            // host releases its strobe once data is taken
            if (!strobeAct)
            begin
               state_d = ST_IDLE;
            end
         end
         ST_WR_LATCH:
         begin
            if (!strobeAct)
            begin
               if (acc_q[0] && (!muxMode_q || second_q))
               begin
                  state_d = ST_WR_MEM;
               end
               else
               begin
                  state_d = ST_IDLE;
               end
            end
         end
         ST_WR_MEM:
         begin
            if (hostGnt)
            begin
               state_d = ST_IDLE;
            end
         end
         default:
         begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         state_q <= ST_IDLE;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   assign wrRise = (state_q == ST_WR_LATCH) & ~strobeAct & ~dirRead_q;
   assign incRead = (state_q == ST_RD_MEM) & hostGnt & (acc_q == ACC_DATA_INC);
   assign incWrite = (state_q == ST_WR_MEM) & hostGnt & (acc_q == ACC_DATA_INC);

   // control register, written by the host only
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         portControlReg_q <= CTL_RESET;
      end
      else if (wrRise && acc_q == ACC_CTRL)
      begin
         portControlReg_q <= merge(portControlReg_q, pin_q.data, muxMode_q,
                                   laneHigh(second_q, byteOrderBit)) & CTL_WR_MASK;
      end
   end

   // address registers
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         readAddrReg_q <= ADDR_RESET;
         writeAddrReg_q <= ADDR_RESET;
      end
      else if (capture && !muxMode_q)
      begin
         // wide mode: 15-bit address, top bit dropped
         readAddrReg_q <= {1'b0, pin_q.addr[MEM_AW-1:0]};
         writeAddrReg_q <= {1'b0, pin_q.addr[MEM_AW-1:0]};
      end
      else if (wrRise && acc_q == ACC_ADDR)
      begin
         if (!dualAddrBit || addrRegSelectBit)
         begin
            readAddrReg_q <= merge(addrView, pin_q.data, 1'b1,
                                   laneHigh(second_q, byteOrderBit));
         end
         if (!dualAddrBit || !addrRegSelectBit)
         begin
            writeAddrReg_q <= merge(addrView, pin_q.data, 1'b1,
                                    laneHigh(second_q, byteOrderBit));
         end
      end
      else if (incRead || incWrite)
      begin
         // post-increment wraps at the register width
         if (!dualAddrBit || incRead)
         begin
            readAddrReg_q <= readAddrReg_q + 16'h0001;
         end
         if (!dualAddrBit || incWrite)
         begin
            writeAddrReg_q <= writeAddrReg_q + 16'h0001;
         end
      end
   end

   // data register
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         dataWindowReg_q <= DATA_RESET;
      end
      else if (state_q == ST_RD_DATA)
      begin
         dataWindowReg_q <= memRdata;
      end
      else if (wrRise && acc_q[0])
      begin
         dataWindowReg_q <= merge(dataWindowReg_q, pin_q.data, muxMode_q,
                                  laneHigh(second_q, byteOrderBit));
      end
   end

   // read data held on the bus until the strobe is released
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         hostDataOut_q <= DATA_RESET;
      end
      else if (state_q == ST_RD_DATA)
      begin
         hostDataOut_q <= readSel(memRdata, muxMode_q, laneHigh(second_q, byteOrderBit));
      end
      else if (capture && curDirRead)
      begin
         case (curAcc)
            ACC_CTRL:
            begin
               hostDataOut_q <= readSel(ctrlView, muxMode_q,
                                        laneHigh(curSecond, byteOrderBit));
            end
            ACC_ADDR:
            begin
               hostDataOut_q <= curValid ? readSel(addrView, 1'b1,
                                        laneHigh(curSecond, byteOrderBit)) : DATA_RESET;
            end
            default:
            begin
               hostDataOut_q <= curValid ? readSel(dataWindowReg_q, 1'b1,
                                        laneHigh(curSecond, byteOrderBit)) : DATA_RESET;
            end
         endcase
      end
   end

   assign hostDataOut = hostDataOut_q;
   assign hostDataOe = (state_q == ST_RD_HOLD) & strobeAct;

   // busy while memory is pending, a strobe is not yet taken or read data not yet loaded
   assign busy = (state_q == ST_RD_MEM) | (state_q == ST_RD_DATA) | (state_q == ST_WR_MEM)
                 | (strobeAct & ~captured_q & ~(capture & ~curDirRead));
   assign portReadyOut = ~csActive | ~portOn | ~busy;

   // dma path: read register for reads, write register for writes
   assign memAddr = (state_q == ST_WR_MEM) ? writeAddrReg_q[MEM_AW-1:0]
                                           : readAddrReg_q[MEM_AW-1:0];
   assign memEnable = hostGnt;
   assign memWrite = hostGnt & (state_q == ST_WR_MEM);
   assign memWdata = dataWindowReg_q;

   assign arbBus.cpuReq = cpuReq;
   assign arbBus.cpuBlock = cpuBlock;
   assign arbBus.dmacReq = dmacReq;
   assign arbBus.dmacBlock = dmacBlock;
   assign arbBus.hostReq = (state_q == ST_RD_MEM) | (state_q == ST_WR_MEM);
   assign arbBus.hostBlock = blockOf(memAddr);
   assign hostGnt = arbBus.hostGnt;
   assign dmacGrant = arbBus.dmacGnt;

   dual_ram_arbiter uArb
   (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .arb(arbBus.arbiter)
   );

   assign muxModeOut = muxMode_q;
   assign portEnabledOut = portOn;
endmodule

// ==== include/host_port_pkg.sv ====
// Purpose: shared constants and types of the host port block
// Assumes: 32K words of memory, eight dual-access blocks of 4K words
// Notes: control register bit positions are fixed here
package host_port_pkg;
   localparam int ADDR_W = 16;
   localparam int MEM_AW = 15;
   localparam int DATA_W = 16;
   localparam int BLOCK_W = 3;
   localparam int BLOCK_LSB = 12;

   typedef enum logic [1:0]
   {
      ACC_CTRL = 2'h0,
      ACC_DATA_INC = 2'h1,
      ACC_ADDR = 2'h2,
      ACC_DATA = 2'h3
   } access_e;

   localparam int CTL_BOB_BIT = 0;
   localparam int CTL_DUAL_BIT = 3;
   localparam int CTL_SEL_BIT = 4;
   localparam int CTL_BOB_STAT_BIT = 8;
   localparam logic [15:0] CTL_WR_MASK = 16'h0019;
   localparam logic [15:0] CTL_RESET = 16'h0000;
   localparam logic [15:0] ADDR_RESET = 16'h0000;
   localparam logic [15:0] DATA_RESET = 16'h0000;

   // settle time of the pin synchroniser before the strap is trusted
   localparam logic [2:0] STRAP_WAIT = 3'h4;

   typedef enum logic [2:0]
   {
      ST_IDLE = 3'h0,
      ST_RD_MEM = 3'h1,
      ST_RD_DATA = 3'h3,
      ST_RD_HOLD = 3'h2,
      ST_WR_LATCH = 3'h4,
      ST_WR_MEM = 3'h5
   } state_e;

   typedef struct packed
   {
      logic selN;
      logic strobeAN;
      logic strobeBN;
      logic addrStrobeN;
      logic [1:0] acc;
      logic dirRead;
      logic byteId;
      logic [15:0] addr;
      logic [15:0] data;
      logic strap;
   } pins_s;

   function automatic logic [BLOCK_W-1:0] blockOf(input logic [MEM_AW-1:0] a);
      blockOf = a[BLOCK_LSB +: BLOCK_W];
   endfunction
endpackage

// ==== include/mem_arb_if.sv ====
// Purpose: request and grant wires between the port and the memory arbiter
// Assumes: one request per master per cycle
// Notes: block number picks one dual-access block
interface mem_arb_if
   import host_port_pkg::*;
   ();
   logic cpuReq;
   logic [BLOCK_W-1:0] cpuBlock;
   logic hostReq;
   logic [BLOCK_W-1:0] hostBlock;
   logic hostGnt;
   logic dmacReq;
   logic [BLOCK_W-1:0] dmacBlock;
   logic dmacGnt;

   modport arbiter
   (
      input cpuReq, cpuBlock, hostReq, hostBlock, dmacReq, dmacBlock,
      output hostGnt, dmacGnt
   );
   modport requester
   (
      output cpuReq, cpuBlock, hostReq, hostBlock, dmacReq, dmacBlock,
      input hostGnt, dmacGnt
   );
endinterface

// ==== logic/dual_ram_arbiter.sv ====
// Purpose: arbitration of host path and dma controller against the cpu
// Assumes: cpu always proceeds; top bit of the block number names the half
// Notes: one round-robin pointer per half
module dual_ram_arbiter
   import host_port_pkg::*;
   (
      // clock and reset
      input wire logic clk_sys,
      input wire logic resetn,
      // masters
      mem_arb_if.arbiter arb
   );

   logic [1:0] favorHost_q;
   logic hostOk;
   logic dmacOk;
   logic clash;
   logic half;

   // cpu owns a block it asks for
   assign hostOk = arb.hostReq & ~(arb.cpuReq & (arb.cpuBlock == arb.hostBlock));
   assign dmacOk = arb.dmacReq & ~(arb.cpuReq & (arb.cpuBlock == arb.dmacBlock));
   assign half = arb.hostBlock[BLOCK_W-1];
   assign clash = hostOk & dmacOk & (half == arb.dmacBlock[BLOCK_W-1]);
   assign arb.hostGnt = hostOk & (~clash | favorHost_q[half]);
   assign arb.dmacGnt = dmacOk & (~clash | ~favorHost_q[half]);

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         favorHost_q <= 2'h3;
      end
      else if (clash)
      begin
         favorHost_q[half] <= ~favorHost_q[half];
      end
   end
endmodule

// ==== tb/host_port_monitor.sv ====
// Purpose: concurrent checks on the host port pins
// Assumes: sees only the top module ports
// Notes: bound into every host_port instance
module host_port_monitor
   import host_port_pkg::*;
   #(
      parameter bit WIDE_PRESENT = 1'b1
   )
   (
      // clock and reset
      input wire logic clk_sys,
      input wire logic resetn,
      // host side
      input wire logic portSelectN,
      input wire logic hostDataOe,
      input wire logic portReadyOut,
      // memory side
      input wire logic memEnable,
      input wire logic memWrite,
      input wire logic [MEM_AW-1:0] memAddr,
      // other masters
      input wire logic cpuReq,
      input wire logic [BLOCK_W-1:0] cpuBlock,
      input wire logic dmacReq,
      input wire logic [BLOCK_W-1:0] dmacBlock,
      input wire logic dmacGrant,
      // status
      input wire logic muxModeOut,
      input wire logic portEnabledOut
   );
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);

   sequence s_unselected;
      portSelectN [*5];
   endsequence
   sequence s_fetch;
      memEnable && !memWrite;
   endsequence

   a_ready_unselected: assert property (s_unselected |-> portReadyOut)
      else $error("ready low while port not selected");
   a_fetch_ready: assert property (s_fetch |-> !portReadyOut ##2 portReadyOut)
      else $error("ready wrong around a memory fetch");
   a_oe_ready: assert property (hostDataOe |-> portReadyOut)
      else $error("data driven while not ready");
   a_cpu_host: assert property (memEnable && cpuReq |-> cpuBlock != memAddr[14:12])
      else $error("host granted against cpu");
   a_cpu_dmac: assert property (dmacGrant && cpuReq |-> cpuBlock != dmacBlock)
      else $error("dma granted against cpu");
   a_half_shared: assert property (memEnable && dmacGrant |-> dmacBlock[2] != memAddr[14])
      else $error("host and dma granted in one half");
   a_strap_hold: assert property (portEnabledOut && $past(portEnabledOut) |-> $stable(muxModeOut))
      else $error("mode changed while running");
   a_narrow_off: assert property (portEnabledOut |-> muxModeOut || WIDE_PRESENT)
      else $error("narrow port enabled in wide mode");
endmodule

bind host_port host_port_monitor #(.WIDE_PRESENT(WIDE_PRESENT)) u_mon (
   .clk_sys(clk_sys), .resetn(resetn), .portSelectN(portSelectN),
   .hostDataOe(hostDataOe), .portReadyOut(portReadyOut), .memEnable(memEnable),
   .memWrite(memWrite), .memAddr(memAddr), .cpuReq(cpuReq), .cpuBlock(cpuBlock),
   .dmacReq(dmacReq), .dmacBlock(dmacBlock), .dmacGrant(dmacGrant),
   .muxModeOut(muxModeOut), .portEnabledOut(portEnabledOut));

// ==== tb/host_model.sv ====
// Purpose: host processor model driving the port pins
// Assumes: one strobe pin used, the other held high
// Notes: released data lines show the inverse of the last value
module host_model
   import host_port_pkg::*;
   (
      // clock
      input wire logic clk_sys,
      // pins towards the port
      output logic portSelectN,
      output logic dataStrobeAN,
      output logic addrStrobeN,
      output logic [1:0] accessTypeInputs,
      output logic directionInput,
      output logic byteIdLine,
      output logic [ADDR_W-1:0] hostAddrBus,
      output logic [DATA_W-1:0] hostDataIn,
      // answers from the port
      input wire logic portReadyOut,
      input wire logic [DATA_W-1:0] hostDataOut
   );
   timeunit 1ns;
   timeprecision 1ps;
   // set by the bench: control latched by the address strobe
   logic useAs = 1'b0;

   initial
   begin
      portSelectN = 1'b1;
      dataStrobeAN = 1'b1;
      addrStrobeN = 1'b1;
      accessTypeInputs = 2'h0;
      directionInput = 1'b1;
      byteIdLine = 1'b0;
      hostAddrBus = 16'h0000;
      hostDataIn = 16'h0000;
   end

   task automatic xfer(input logic [1:0] c, input logic r, input logic b,
      input logic [15:0] d, input logic [15:0] a, output logic [15:0] q);
      int n;
      n = 0;
      @(negedge clk_sys);
      accessTypeInputs <= c;
      directionInput <= r;
      byteIdLine <= b;
      hostAddrBus <= a;
      hostDataIn <= d;
      addrStrobeN <= ~useAs;
      if (useAs)
      begin
         // control latched early, then scrambled before the strobe
         repeat (5) @(negedge clk_sys);
         accessTypeInputs <= ~c;
         directionInput <= ~r;
         byteIdLine <= ~b;
      end
      portSelectN <= 1'b0;
      dataStrobeAN <= 1'b0;
      // ready is stale until the strobe crosses the synchroniser
      repeat (6) @(negedge clk_sys);
      while (portReadyOut !== 1'b1 && n < 400)
      begin
         @(negedge clk_sys);
         n++;
      end
      q = hostDataOut;
      portSelectN <= 1'b1;
      dataStrobeAN <= 1'b1;
      addrStrobeN <= 1'b1;
      // data held past the strobe rise, then released
      repeat (5) @(negedge clk_sys);
      hostDataIn <= ~d;
      repeat (5) @(negedge clk_sys);
   endtask
endmodule

// ==== tb/host_port_tb.sv ====
// Purpose: self-checking bench of the host port
// Assumes: muxed mode first, wide mode after a second reset
// Notes: memory and the other masters are modelled here
module host_port_tb
   import host_port_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0, resetn = 1'b0, strap = 1'b1;
   logic selN, strA, asN, bil, dir, oe, rdy, men, mwr, dGnt, muxM, pOn;
   logic [1:0] acc;
   logic [15:0] ha, din, dout, wdat, q, rdat = 16'h0000, rnd = 16'h7bbf;
   logic [7:0] oth = 8'h00;
   logic [14:0] madr;
   logic [15:0] mem [0:32767];
   logic [15:0] refM [int];
   int fail_count = 0, n_tests = 0, cyc = 0, aR = 0, aW = 0, dual = 0, sel = 0, byte_order_bit = 0;

   always #2.5 clk_sys = ~clk_sys;

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   host_port uut (.clk_sys(clk_sys), .resetn(resetn), .portSelectN(selN),
      .dataStrobeAN(strA), .dataStrobeBN(1'b1), .addrStrobeN(asN),
      .accessTypeInputs(acc), .directionInput(dir), .byteIdLine(bil),
      .modeStrapPin(strap), .hostAddrBus(ha), .hostDataIn(din), .hostDataOut(dout),
      .hostDataOe(oe), .portReadyOut(rdy), .memEnable(men), .memWrite(mwr),
      .memAddr(madr), .memWdata(wdat), .memRdata(rdat), .cpuReq(oth[7]),
      .cpuBlock(oth[6:4]), .dmacReq(oth[3]), .dmacBlock(oth[2:0]),
      .dmacGrant(dGnt), .muxModeOut(muxM), .portEnabledOut(pOn));

   host_model u_host (.clk_sys(clk_sys), .portSelectN(selN), .dataStrobeAN(strA),
      .addrStrobeN(asN),
      .accessTypeInputs(acc), .directionInput(dir), .byteIdLine(bil),
      .hostAddrBus(ha), .hostDataIn(din), .portReadyOut(rdy), .hostDataOut(dout));

   always @(negedge clk_sys)
   begin
      rnd <= lfsr(rnd);
      oth <= rnd[7:0];
   end

   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      if (men === 1'b1)
      begin
         if (mwr === 1'b1)
            mem[madr] <= wdat;
         rdat <= mem[madr];
      end
      else
         rdat <= ~rdat;
      if (cyc == 30000)
      begin
         fail_count++;
         close_out();
      end
   end

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_tests++;
      if (g !== e)
      begin
         fail_count++;
         $display("ERROR %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic w16(input logic [1:0] c, input logic [15:0] v);
      u_host.xfer(c, 1'b0, 1'b0, {8'h00, byte_order_bit ? v[7:0] : v[15:8]}, 16'h0000, q);
      u_host.xfer(c, 1'b0, 1'b1, {8'h00, byte_order_bit ? v[15:8] : v[7:0]}, 16'h0000, q);
   endtask

   task automatic r16(input logic [1:0] c, output logic [15:0] v);
      u_host.xfer(c, 1'b1, 1'b0, 16'h0000, 16'h0000, q);
      v[7:0] = q[7:0];
      u_host.xfer(c, 1'b1, 1'b1, 16'h0000, 16'h0000, q);
      v[15:8] = q[7:0];
      if (byte_order_bit == 0)
         v = {v[7:0], v[15:8]};
   endtask

   task automatic ctl(input logic [15:0] v);
      w16(2'h0, v);
      dual = v[CTL_DUAL_BIT];
      sel = v[CTL_SEL_BIT];
      byte_order_bit = v[CTL_BOB_BIT];
   endtask

   task automatic awr(input logic [15:0] v);
      w16(2'h2, v);
      if (!dual || sel)
         aR = v;
      if (!dual || !sel)
         aW = v;
   endtask

   task automatic ard();
      logic [15:0] v;
      r16(2'h2, v);
      chk(v, (dual && !sel) ? aW[15:0] : aR[15:0]);
   endtask

   task automatic dwr(input logic inc, input logic [15:0] v);
      w16(inc ? 2'h1 : 2'h3, v);
      refM[aW & 32'h7fff] = v;
      if (inc)
      begin
         aW = (aW + 1) & 32'hffff;
         if (!dual)
            aR = (aR + 1) & 32'hffff;
      end
   endtask

   task automatic drd(input logic inc);
      logic [15:0] v;
      r16(inc ? 2'h1 : 2'h3, v);
      chk(v, refM[aR & 32'h7fff]);
      if (inc)
      begin
         aR = (aR + 1) & 32'hffff;
         if (!dual)
            aW = (aW + 1) & 32'hffff;
      end
   endtask

   initial
   begin
      logic [15:0] a1, v;
      repeat (16) @(negedge clk_sys);
      resetn <= 1'b1;
      repeat (12) @(negedge clk_sys);
      chk({15'h0000, muxM}, 16'h0001);
      ctl(16'h0001);
      r16(2'h0, v);
      chk(v, 16'h0101);
      a1 = rnd;
      awr(a1);
      ard();
      repeat (4) dwr(1'b1, rnd);
      ard();
      awr(a1);
      repeat (4) drd(1'b1);
      awr(16'hffff);
      dwr(1'b1, rnd);
      ard();
      u_host.useAs = 1'b1;
      ctl(16'h0019);
      awr(a1);
      ctl(16'h0009);
      awr(a1 ^ 16'h4000);
      ard();
      repeat (2) dwr(1'b1, rnd);
      ctl(16'h0019);
      ard();
      repeat (2) drd(1'b1);
      ard();
      ctl(16'h0009);
      ard();
      ctl(16'h0001);
      awr(a1);
      dwr(1'b0, rnd);
      awr(a1);
      drd(1'b0);
      ard();
      u_host.useAs = 1'b0;
      resetn <= 1'b0;
      strap <= 1'b0;
      repeat (16) @(negedge clk_sys);
      resetn <= 1'b1;
      repeat (12) @(negedge clk_sys);
      chk({15'h0000, muxM}, 16'h0000);
      repeat (3)
      begin
         a1 = rnd;
         v = lfsr(a1);
         u_host.xfer(2'h3, 1'b0, a1[0], v, a1 | 16'h8000, q);
         u_host.xfer(2'h3, 1'b1, a1[1], 16'h0000, a1 & 16'h7fff, q);
         chk(q, v);
      end
      u_host.xfer(2'h1, 1'b1, 1'b0, 16'h0000, a1, q);
      chk(q, 16'h0000);
      close_out();
   end
endmodule
